// ===== irt_consts.svh
// Constants of the infrared transmit and learning block
`ifndef IRT_CONSTS_SVH
`define IRT_CONSTS_SVH
// ==========================================================
// Timing
`define IRT_CLK_NS        25
`define IRT_US_NS         1000
`define IRT_US_CYC        ((`IRT_US_NS + `IRT_CLK_NS - 1) / `IRT_CLK_NS)
`define IRT_CAR_MAX_HZ    500000
`define IRT_CAR_MIN_HZ    10000
`define IRT_CAR_MIN_CYC   (1000000000 / (`IRT_CAR_MAX_HZ * `IRT_CLK_NS))
`define IRT_CAR_MAX_CYC   (1000000000 / (`IRT_CAR_MIN_HZ * `IRT_CLK_NS))
`define IRT_ENV_HOLD_NS   110000
`define IRT_ENV_HOLD_CYC  (`IRT_ENV_HOLD_NS / `IRT_CLK_NS)
`define IRT_DUR_MAX       15'h7fff
`define IRT_FIFO_DEPTH    8
// ==========================================================
// Register offsets
`define IRT_OFF_CTRL      8'h00
`define IRT_OFF_CARRIER   8'h04
`define IRT_OFF_DESC      8'h08
`define IRT_OFF_STATUS    8'h0c
`define IRT_OFF_LEARN     8'h10
`define IRT_OFF_CARMEAS   8'h14
// ==========================================================
// Control fields and reset values
`define IRT_CTRL_EN       0
`define IRT_CTRL_MOD      1
`define IRT_CTRL_SRC_LO   2
`define IRT_CTRL_BIT      4
`define IRT_CTRL_LRN      5
`define IRT_CTRL_RST      6'h00
`define IRT_CAR_HALF_RST  16'h020e
`define IRT_DESC_LVL      15
`endif

// ===== irt_pkg.sv
// Types of the infrared transmit and learning block
`default_nettype none
package irt_pkg;
  // Transmit waveform source
  typedef enum logic [1:0] {
    IRT_SRC_FIFO,
    IRT_SRC_BIT,
    IRT_SRC_UART,
    IRT_SRC_NONE
  } irt_src_t;
endpackage
`default_nettype wire

// ===== irt_top.sv
// Infrared transmit modulator and learning receiver with APB registers
`timescale 1ns/1ps
`default_nettype none
`include "irt_consts.svh"
// ==========================================================
module irt_top #(
  parameter int unsigned ENV_HOLD_CYC = `IRT_ENV_HOLD_CYC
) (
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic        uart_txd,
  input  wire logic        ir_rx_in,
  output logic             ir_tx_out
);
  localparam logic [5:0]  US_LAST  = 6'(`IRT_US_CYC - 1);
  localparam logic [15:0] CAR_MIN  = 16'(`IRT_CAR_MIN_CYC);
  localparam logic [15:0] CAR_MAX  = 16'(`IRT_CAR_MAX_CYC);
  localparam logic [15:0] HOLD_CYC = 16'(ENV_HOLD_CYC);
  localparam logic [3:0]  DEPTH    = 4'(`IRT_FIFO_DEPTH);
  // ========================================================
  // APB decode; every access completes without wait states
  logic        acc;          // Access phase
  logic        wr;           // Write takes effect
  logic        rd_learn;     // Read of the learned interval pops it
  logic        sel_map;      // Address hits a register
  logic [31:0] rd_mux;       // Read data selected in setup
  assign acc      = psel & penable;
  assign wr       = acc & pwrite;
  assign rd_learn = acc & ~pwrite & (paddr == `IRT_OFF_LEARN);
  assign sel_map  = (paddr == `IRT_OFF_CTRL) | (paddr == `IRT_OFF_CARRIER) |
                    (paddr == `IRT_OFF_DESC) | (paddr == `IRT_OFF_STATUS) |
                    (paddr == `IRT_OFF_LEARN) | (paddr == `IRT_OFF_CARMEAS);
  assign pready   = 1'b1;
  assign pslverr  = acc & ~sel_map;
  // ========================================================
  // Control registers
  logic [5:0]       ctrl_r;     // Enable, mode, source, bit, learn
  logic [15:0]      car_half_r; // Carrier half period in clocks
  logic             en;
  logic             mod;
  irt_pkg::irt_src_t src;
  assign en  = ctrl_r[`IRT_CTRL_EN];
  assign mod = ctrl_r[`IRT_CTRL_MOD];
  assign src = irt_pkg::irt_src_t'(ctrl_r[`IRT_CTRL_SRC_LO +: 2]);
  // Control writes
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_r     <= `IRT_CTRL_RST;
      car_half_r <= `IRT_CAR_HALF_RST;
    end else if (wr && paddr == `IRT_OFF_CTRL) begin
      ctrl_r <= pwdata[5:0];
    end else if (wr && paddr == `IRT_OFF_CARRIER) begin
      car_half_r <= pwdata[15:0];
    end
  end

  // ========================================================
  // Descriptor FIFO; zero durations are refused, as are pushes when full
  logic [15:0] fifo_mem [0:`IRT_FIFO_DEPTH-1];
  logic [2:0]  wp_r;        // Write pointer
  logic [2:0]  rp_r;        // Read pointer
  logic [3:0]  cnt_r;       // Entries held
  logic        push;
  logic        ld;          // Player takes the head entry
  logic [15:0] head;
  assign push = wr && paddr == `IRT_OFF_DESC && cnt_r != DEPTH && pwdata[14:0] != 15'h0000;
  assign head = fifo_mem[rp_r];
  // Storage has no reset; it is only read once written
  always_ff @(posedge pclk) begin
    if (push) begin
      fifo_mem[wp_r] <= pwdata[15:0];
    end
  end
  // Pointers and fill level
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      wp_r  <= 3'h0;
      rp_r  <= 3'h0;
      cnt_r <= 4'h0;
    end else begin
      wp_r  <= push ? wp_r + 3'h1 : wp_r;
      rp_r  <= ld ? rp_r + 3'h1 : rp_r;
      cnt_r <= cnt_r + {3'h0, push} - {3'h0, ld};
    end
  end

  // ========================================================
  // Descriptor player: prescaler restarts on each load so a
  // descriptor lasts exactly duration times the microsecond period
  logic        play_on_r;   // A descriptor is playing
  logic        play_lvl_r;  // Its on/off level
  logic [14:0] rem_r;       // Microseconds left
  logic [5:0]  pre_r;       // Microsecond prescaler
  logic        tick_tx;
  logic        fin;
  logic        run_fifo;
  assign run_fifo = en && src == irt_pkg::IRT_SRC_FIFO;
  assign tick_tx  = pre_r == US_LAST;
  assign fin      = play_on_r && tick_tx && rem_r == 15'h0001;
  assign ld       = run_fifo && cnt_r != 4'h0 && (!play_on_r || fin);
  // Player state
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      play_on_r  <= 1'b0;
      play_lvl_r <= 1'b0;
      rem_r      <= 15'h0000;
      pre_r      <= 6'h00;
    end else if (!run_fifo || (fin && !ld)) begin
      // Stopped or drained: rest off
      play_on_r  <= 1'b0;
      play_lvl_r <= 1'b0;
      pre_r      <= 6'h00;
    end else if (ld) begin
      play_on_r  <= 1'b1;
      play_lvl_r <= head[`IRT_DESC_LVL];
      rem_r      <= head[14:0];
      pre_r      <= 6'h00;
    end else if (play_on_r) begin
      pre_r <= tick_tx ? 6'h00 : pre_r + 6'h01;
      rem_r <= tick_tx ? rem_r - 15'h0001 : rem_r;
    end
  end

  // ========================================================
  // Source select and carrier gating
  logic        env;         // Wanted on/off level
  logic [15:0] car_cnt_r;
  logic        car_r;       // Carrier phase, starts high on each burst
  logic        out_r;
  always_comb begin
    unique case (src)
      irt_pkg::IRT_SRC_FIFO: env = en & play_on_r & play_lvl_r;
      irt_pkg::IRT_SRC_BIT:  env = en & ctrl_r[`IRT_CTRL_BIT];
      irt_pkg::IRT_SRC_UART: env = en & ~uart_txd; // UART idles high, i.e. off
      irt_pkg::IRT_SRC_NONE: env = 1'b0;
    endcase
  end
  // Carrier counter; restarted while off so bursts begin in phase
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      car_cnt_r <= 16'h0000;
      car_r     <= 1'b1;
      out_r     <= 1'b0;
    end else begin
      if (!env || car_cnt_r >= car_half_r - 16'h0001) begin
        car_cnt_r <= 16'h0000;
        car_r     <= env ? ~car_r : 1'b1;
      end else begin
        car_cnt_r <= car_cnt_r + 16'h0001;
      end
      out_r <= env & (~mod | car_r);
    end
  end
  assign ir_tx_out = out_r;
  // ========================================================
  // Learning: presence is a high input or one last seen high within the
  // hold window, so a bare level and a 10 kHz carrier both count
  logic        rx_d_r;      // Input one cycle ago
  logic        rise;
  logic [15:0] hold_r;      // Clocks since input was last high
  logic        pres;
  logic        pres_r;
  logic [15:0] per_r;       // Clocks since last rising edge
  logic [15:0] meas_r;      // Last in-range carrier period
  logic [5:0]  lpre_r;      // Free-running microsecond prescaler
  logic [14:0] dur_r;       // Current interval, microseconds
  logic [15:0] lrn_r;       // Level and duration, descriptor layout
  logic        lrn_vld_r;
  logic        ovf_r;       // Interval lost while one was unread
  logic        lrn_en;
  logic        cap;
  assign lrn_en = ctrl_r[`IRT_CTRL_LRN];
  assign rise   = ir_rx_in & ~rx_d_r;
  assign pres   = ir_rx_in | (hold_r < HOLD_CYC);
  assign cap    = lrn_en && pres != pres_r;
  // Saturating count; a stuck maximum means "long ago", never a wrap to zero
  function automatic logic [15:0] sat_inc(input logic [15:0] v);
    return (v == 16'hffff) ? v : v + 16'h0001;
  endfunction
  // Envelope, carrier period and interval timing
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rx_d_r <= 1'b0;
      hold_r <= 16'hffff;
      pres_r <= 1'b0;
      per_r  <= 16'hffff;
      meas_r <= 16'h0000;
      lpre_r <= 6'h00;
      dur_r  <= 15'h0000;
    end else begin
      rx_d_r <= ir_rx_in;
      hold_r <= ir_rx_in ? 16'h0000 : sat_inc(hold_r);
      pres_r <= pres;
      per_r  <= rise ? 16'h0001 : sat_inc(per_r);
      if (rise && per_r >= CAR_MIN && per_r <= CAR_MAX) begin
        meas_r <= per_r;
      end
      lpre_r <= (lpre_r == US_LAST) ? 6'h00 : lpre_r + 6'h01;
      if (cap) begin
        dur_r <= 15'h0000;
      end else if (lpre_r == US_LAST && dur_r != `IRT_DUR_MAX) begin
        dur_r <= dur_r + 15'h0001;
      end
    end
  end
  // Learned interval holder; a new capture wins over the pop
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      lrn_r     <= 16'h0000;
      lrn_vld_r <= 1'b0;
      ovf_r     <= 1'b0;
    end else begin
      if (cap) begin
        lrn_r <= {pres_r, dur_r};
      end
      lrn_vld_r <= cap | (lrn_vld_r & ~rd_learn);
      ovf_r     <= (cap & lrn_vld_r & ~rd_learn) |
                   (ovf_r & ~(wr && paddr == `IRT_OFF_STATUS));
    end
  end

  // ========================================================
  // Read data, captured in the setup phase
  always_comb begin
    unique case (paddr)
      `IRT_OFF_CTRL:    rd_mux = {26'h0, ctrl_r};
      `IRT_OFF_CARRIER: rd_mux = {16'h0, car_half_r};
      `IRT_OFF_STATUS:  rd_mux = {22'h0, ovf_r, lrn_vld_r, out_r, play_on_r, cnt_r,
                                  cnt_r == DEPTH, cnt_r == 4'h0};
      `IRT_OFF_LEARN:   rd_mux = {lrn_vld_r, 15'h0, lrn_r};
      `IRT_OFF_CARMEAS: rd_mux = {16'h0, meas_r};
      default:          rd_mux = 32'h0000_0000;
    endcase
  end
  // Read data register
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h0000_0000;
    end else if (psel && !penable && !pwrite) begin
      prdata <= rd_mux;
    end
  end

  // ========================================================
  // Checks
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  sequence tick_s;
    tick_tx && play_on_r;
  endsequence
  sequence quiet_s;
    !tick_tx [*8];
  endsequence
  off_when_idle_a: assert property (!env |=> !ir_tx_out)
    else $error("output on while source idle");
  plain_on_a: assert property (en && !mod && env |=> ir_tx_out)
    else $error("unmodulated on interval not driven");
  carrier_gate_a: assert property (mod && env && car_r |=> ir_tx_out)
    else $error("carrier phase not gated onto output");
  bit_source_a: assert property (en && src == irt_pkg::IRT_SRC_BIT && !mod &&
                  ctrl_r[`IRT_CTRL_BIT] |=> ir_tx_out)
    else $error("control bit source not followed");
  desc_count_a: assert property (tick_s ##0 (run_fifo && rem_r > 15'h0001 && !ld)
                  |=> rem_r == $past(rem_r) - 15'h0001)
    else $error("descriptor time not counted down");
  fifo_fill_a: assert property (push && !ld |=> cnt_r == $past(cnt_r) + 4'h1)
    else $error("descriptor not queued");
  us_tick_a: assert property (tick_s |=> quiet_s)
    else $error("microsecond tick too fast");
  learn_cap_a: assert property (cap |=> lrn_vld_r && lrn_r[15] == $past(pres_r))
    else $error("interval not captured");
  car_range_a: assert property ($changed(meas_r) |-> meas_r >= CAR_MIN &&
                  meas_r <= CAR_MAX)
    else $error("carrier period out of range");
endmodule
`default_nettype wire

// ===== irt_ir_peer.sv
// Model of the emitter and the infrared receiver beside the block
`timescale 1ns/1ps
`default_nettype none
module irt_ir_peer (
  input  wire logic pclk,
  input  wire logic ir_tx_out,
  output var  logic ir_rx_in
);
  // ==========================================================
  // Emitter side
  int lit;  // Clocks with the emitter lit, read by the bench
  // Count lit clocks so the bench can weigh any window
  always @(posedge pclk) begin
    if (ir_tx_out === 1'b1) begin
      lit <= lit + 1;
    end
  end
  // ==========================================================
  // Receiver side: output rests low while no light is seen
  initial begin
    lit      = 0;
    ir_rx_in = 1'b0;
  end
  // Steady light for n clocks, then dark
  task automatic plain(input int n);
    ir_rx_in <= 1'b1;
    repeat (n) @(posedge pclk);
    ir_rx_in <= 1'b0;
  endtask
  // Carrier burst of n periods of p clocks, lit half first
  task automatic burst(input int p, input int n);
    repeat (n) begin
      ir_rx_in <= 1'b1;
      repeat (p / 2) @(posedge pclk);
      ir_rx_in <= 1'b0;
      repeat (p / 2) @(posedge pclk);
    end
  endtask
endmodule
`default_nettype wire

// ===== infrared_tx_and_learning_bench.sv
// Self-checking bench of the infrared transmit and learning block
`timescale 1ns/1ps
`default_nettype none
module infrared_tx_and_learning_bench;
  // ==========================================================
  // Signals
  logic        pclk, presetn, psel, penable, pwrite;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata;
  logic        pready, pslverr, uart_txd, ir_rx_in, ir_tx_out;
  logic [31:0] rd;           // Data of the last read
  logic        er;           // Error flag of the last access
  logic [14:0] lu;           // Learned microseconds
  int          mismatches, check_count, n, i, base;
  // Short hold window keeps learning runs brief
  irt_top #(.ENV_HOLD_CYC(200)) dut (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .uart_txd(uart_txd),
    .ir_rx_in(ir_rx_in), .ir_tx_out(ir_tx_out));
  irt_ir_peer peer (.pclk(pclk), .ir_tx_out(ir_tx_out), .ir_rx_in(ir_rx_in));
  // 40 MHz clock
  initial begin
    pclk = 1'b0;
    forever #12.5 pclk = ~pclk;
  end
  // ==========================================================
  // Tasks
  task automatic close_out();
    $display("checks %0d mismatches %0d", check_count, mismatches);
    if (mismatches == 0 && check_count > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      mismatches++;
      $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  // One APB transfer; entered just after a rising edge
  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    // Request stays put until pready is seen high; only the watchdog ends a wait
    while (pready !== 1'b1) begin
      @(posedge pclk);
    end
    rd = prdata;
    er = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask
  // Wait, bounded, for the emitter to show level l
  task automatic wait_lvl(input logic l);
    int k;
    k = 0;
    while (ir_tx_out !== l && k < 4000) begin
      k++;
      @(posedge pclk);
    end
    // A level that never shows is a mismatch, not a silent pass
    chk({31'h0, ir_tx_out === l}, 32'h0000_0001);
  endtask
  // Clocks that level l holds, capped at lim
  task automatic meas(input logic l, input int lim);
    n = 0;
    while (ir_tx_out === l && n < lim) begin
      n++;
      @(posedge pclk);
    end
  endtask
  // ==========================================================
  // Watchdog: the whole sequence needs under 20000 clocks
  initial begin
    repeat (40000) @(posedge pclk);
    mismatches++;
    close_out();
  end
  // ==========================================================
  // Main sequence
  logic [31:0] ctl [7] = '{32'h0000_0015, 32'h0000_0005, 32'h0000_0009, 32'h0000_0009,
                           32'h0000_0017, 32'h0000_001d, 32'h0000_0014};
  logic        ut  [7] = '{1'b1, 1'b1, 1'b0, 1'b1, 1'b1, 1'b1, 1'b1};
  int          lt  [7] = '{80, 0, 80, 0, 40, 0, 0};
  initial begin
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0000_0000;
    uart_txd = 1'b1;
    mismatches = 0;
    check_count = 0;
    repeat (20) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    // Reset values and an unmapped place
    xfer(1'b0, 8'h00, 32'h0000_0000);
    chk(rd, 32'h0000_0000);
    xfer(1'b0, 8'h04, 32'h0000_0000);
    chk(rd, 32'h0000_020e);
    xfer(1'b0, 8'h0c, 32'h0000_0000);
    chk(rd, 32'h0000_0001);
    xfer(1'b0, 8'h18, 32'h0000_0000);
    chk({er, rd[30:0]}, 32'h8000_0000);
    // Bit, UART and idle sources, plain and with a 4-clock half period
    xfer(1'b1, 8'h04, 32'h0000_0004);
    for (i = 0; i < 7; i++) begin
      uart_txd <= ut[i];
      xfer(1'b1, 8'h00, ctl[i]);
      repeat (4) @(posedge pclk);
      base = peer.lit;
      repeat (80) @(posedge pclk);
      chk(32'(peer.lit - base), 32'(lt[i]));
    end
    // Queue: zero duration refused, ninth entry refused when full
    xfer(1'b1, 8'h00, 32'h0000_0000);
    for (i = 0; i < 10; i++) begin
      xfer(1'b1, 8'h08, (i == 7) ? 32'h0000_8000 : 32'h0000_0001);
      if (i == 7) begin
        xfer(1'b0, 8'h0c, 32'h0000_0000);
        chk(rd, 32'h0000_001c);
      end
    end
    xfer(1'b0, 8'h0c, 32'h0000_0000);
    chk(rd, 32'h0000_0022);
    xfer(1'b1, 8'h00, 32'h0000_0001);
    repeat (400) @(posedge pclk);
    xfer(1'b0, 8'h0c, 32'h0000_0000);
    chk(rd, 32'h0000_0001);
    // Back to back playback with exact microsecond lengths
    xfer(1'b1, 8'h00, 32'h0000_0000);
    xfer(1'b1, 8'h08, 32'h0000_8003);
    xfer(1'b1, 8'h08, 32'h0000_0002);
    xfer(1'b1, 8'h08, 32'h0000_8001);
    xfer(1'b1, 8'h00, 32'h0000_0001);
    wait_lvl(1'b1);
    meas(1'b1, 500);
    chk(32'(n), 32'h0000_0078);
    meas(1'b0, 500);
    chk(32'(n), 32'h0000_0050);
    meas(1'b1, 500);
    chk(32'(n), 32'h0000_0028);
    meas(1'b0, 200);
    chk(32'(n), 32'h0000_00c8);
    // Learning a plain pulse of 800 clocks; hold adds 200
    xfer(1'b1, 8'h00, 32'h0000_0020);
    fork
      peer.plain(800);
      begin
        repeat (400) @(posedge pclk);
        xfer(1'b0, 8'h10, 32'h0000_0000);
        chk({rd[31], rd[15]}, 32'h0000_0002);
      end
    join
    repeat (300) @(posedge pclk);
    xfer(1'b0, 8'h10, 32'h0000_0000);
    chk({rd[31], rd[15]}, 32'h0000_0003);
    lu = rd[14:0];
    chk(32'(lu >= 15'h0018 && lu <= 15'h001a), 32'h0000_0001);
    // Replay the learned length through the queue
    xfer(1'b1, 8'h08, {16'h0000, 1'b1, lu});
    xfer(1'b1, 8'h00, 32'h0000_0001);
    wait_lvl(1'b1);
    meas(1'b1, 5000);
    chk(32'(n), 32'(lu) * 40);
    // A 200 kHz carrier: period of 200 clocks
    xfer(1'b1, 8'h00, 32'h0000_0020);
    peer.burst(200, 20);
    xfer(1'b0, 8'h14, 32'h0000_0000);
    chk(rd, 32'h0000_00c8);
    // Burst end is captured while the burst start is still unread: overflow
    repeat (300) @(posedge pclk);
    xfer(1'b0, 8'h0c, 32'h0000_0000);
    chk(rd, 32'h0000_0301);
    xfer(1'b1, 8'h0c, 32'h0000_0000);
    xfer(1'b0, 8'h0c, 32'h0000_0000);
    chk(rd, 32'h0000_0101);
    // Present interval spans 19.5 periods, to the end of the last lit half, plus the hold window
    xfer(1'b0, 8'h10, 32'h0000_0000);
    chk({rd[31], rd[15]}, 32'h0000_0003);
    chk(32'(rd[14:0] >= 15'h0066 && rd[14:0] <= 15'h0067), 32'h0000_0001);
    close_out();
  end
endmodule
`default_nettype wire
